// file: verification/pcc_cycle_config_checker.sv
`default_nettype none

module pcc_cycle_config_checker #(
    parameter int NUM_MODULES = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [15:0] main_counter,
    input wire logic [NUM_MODULES-1:0] pwm_mode_en,
    input wire logic [NUM_MODULES-1:0] wide_pwm_select,
    input wire logic [7:0] sfr_rdata,
    input wire logic cycle_overflow_irq,
    input wire logic cycle_overflow_flag,
    input wire logic [NUM_MODULES*5-1:0] module_cycle_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] up_reg;
    wire logic cfg_wr = sfr_wr && sfr_addr == 8'hF4;
    wire logic clr_wr = cfg_wr && !sfr_wdata[5];
    wire logic set_wr = cfg_wr && sfr_wdata[5];

    // Ignore the first three clock edges after release
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            up_reg <= 2'h0;
        else if (up_reg != 2'h3)
            up_reg <= up_reg + 2'h1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (up_reg != 2'h3);

    // ----
    // Assertions
    // ----
    a_irq_needs_flag: assert property (cycle_overflow_irq |-> $past(cycle_overflow_flag))
        else $error("irq without flag");
    a_flag_sticky: assert property ($fell(cycle_overflow_flag) |-> $past(clr_wr))
        else $error("flag dropped without clear");
    a_flag_sw_set: assert property (set_wr |=> cycle_overflow_flag)
        else $error("flag not set by write");
    a_rsvd_read_zero: assert property (sfr_rd && sfr_addr == 8'hF4 |=> sfr_rdata[4:2] == 3'h0)
        else $error("reserved bits nonzero");
    a_pwm_off_bits: assert property (!pwm_mode_en[0] |=> module_cycle_bits[4:0] == 5'h00)
        else $error("cycle bits with pwm off");
    a_wide_cycle_bits: assert property (pwm_mode_en[1] && wide_pwm_select[1]
        |=> module_cycle_bits[9:5] == 5'h10)
        else $error("wide module not 16 bits");
    a_ovf_len_eight: assert property ($fell(main_counter[7]) && module_cycle_bits[4:0] == 5'h08
        |=> cycle_overflow_flag)
        else $error("no overflow at bit 7");
    a_ovf_len_eleven: assert property ($fell(main_counter[10]) && module_cycle_bits[4:0] == 5'h0B
        |=> cycle_overflow_flag)
        else $error("no overflow at bit 10");
endmodule : pcc_cycle_config_checker

`default_nettype wire

// file: verification/pcc_cycle_config_tb.sv
`default_nettype none

module pcc_cycle_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NM = 3;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [15:0] main_counter = 16'h0000;
    logic [NM-1:0] pwm_mode_en = '0;
    logic [NM-1:0] wide_pwm_select = '0;
    logic [7:0] sfr_rdata;
    logic cycle_overflow_irq;
    logic cycle_overflow_flag;
    logic [NM*16-1:0] module_compare_value;
    logic [NM*5-1:0] module_cycle_bits;
    int n_fail = 0;
    int checked = 0;
    logic [15:0] cmp0, rl0, cmp1;
    logic [7:0] d;

    always #4 clk = ~clk;

    pcc_cycle_config #(.NUM_MODULES(NM)) i_pcc_cycle_config (.clk, .resetn, .sfr_addr, .sfr_wdata, .sfr_wr,
        .sfr_rd, .main_counter, .pwm_mode_en, .wide_pwm_select, .sfr_rdata, .cycle_overflow_irq,
        .cycle_overflow_flag, .module_compare_value, .module_cycle_bits);

    // ----
    // Tasks
    // ----
    task automatic end_of_test;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic wr16(input logic [7:0] i, input logic [15:0] v);
        wr(8'hE0 + i, v[7:0]);
        wr(8'hE8 + i, v[15:8]);
    endtask : wr16

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 chk(16'(sfr_rdata), 16'(e));
    endtask : rd

    function automatic logic [4:0] len_bits(input logic [1:0] l);
        return 5'h08 + {3'h0, l};
    endfunction : len_bits

    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(32'h628F07BB));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'hF4, 8'h00);
        repeat (6)
        begin
            d = 8'($urandom);
            wr(8'hF4, d);
            rd(8'hF4, d & 8'hE3);
        end
        wr(8'hF4, 8'h20);
        step(1);
        chk(16'(cycle_overflow_flag), 16'h0001);
        cmp0 = 16'($urandom);
        rl0 = 16'($urandom);
        cmp1 = 16'($urandom);
        @(posedge clk);
        pwm_mode_en <= 3'b011;
        wide_pwm_select <= 3'b010;
        wr(8'hF4, 8'h00);
        wr16(8'h00, cmp0);
        wr16(8'h01, cmp1);
        wr(8'hF4, 8'h80);
        wr16(8'h00, rl0);
        wr16(8'h01, rl0);
        rd(8'hE8, rl0[15:8]);
        wr(8'hF4, 8'h00);
        rd(8'hE8, cmp0[15:8]);
        for (int l = 0; l < 4; l++)
        begin
            wr(8'hF4, {1'b0, l[0], 4'h0, l[1:0]});
            step(2);
            chk({1'b0, module_cycle_bits}, {1'b0, 5'h00, 5'h10, len_bits(l[1:0])});
            @(posedge clk);
            main_counter <= 16'h0001 << (7 + l);
            @(posedge clk);
            main_counter <= 16'h0000;
            step(3);
            chk(16'(cycle_overflow_flag), 16'h0001);
            chk(16'(cycle_overflow_irq), 16'(l[0]));
            chk(module_compare_value[15:0], l == 0 ? cmp0 : rl0);
            chk(module_compare_value[31:16], cmp1);
            wr(8'hF4, {6'h00, l[1:0]});
            step(2);
            chk({14'h0000, cycle_overflow_flag, cycle_overflow_irq}, 16'h0000);
        end
        end_of_test();
    end
endmodule : pcc_cycle_config_tb

bind pcc_cycle_config pcc_cycle_config_checker #(.NUM_MODULES(NUM_MODULES)) i_chk (.clk, .resetn, .sfr_addr,
    .sfr_wdata, .sfr_wr, .sfr_rd, .main_counter, .pwm_mode_en, .wide_pwm_select, .sfr_rdata,
    .cycle_overflow_irq, .cycle_overflow_flag, .module_cycle_bits);

`default_nettype wire

// file: verilog/pcc_cycle_config.sv
// Functional notes
// - The reload bank select bit 7 sends compare high/low accesses to compare values at 0, reload values at 1.
// - Reload values only act as reload of modules in 9, 10 or 11-bit PWM and otherwise do nothing.
// - With the overflow enable bit 6 set, a set overflow flag raises the interrupt request; cleared, it does not.
// - The overflow flag is set when the main counter overflows out of bit 7, 8, 9 or 10 as the length selects.
// - The overflow flag bit 5 is set by hardware or by writing 1 and stays set until software clears it.
// - Bits 4 to 2 of the configuration register read zero and ignore writes.
// - Length code 00 gives 8 bits, 01 gives 9 bits and 10 gives 10 bits.
// - The length applies to every PWM module not in 16-bit mode; 16-bit modules ignore it.
// - A module's wide select chooses 8 to 11-bit PWM at 0 and 16-bit PWM at 1 while PWM is on.
`default_nettype none

module pcc_cycle_config #(
    parameter int NUM_MODULES = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [15:0] main_counter,
    input wire logic [NUM_MODULES-1:0] pwm_mode_en,
    input wire logic [NUM_MODULES-1:0] wide_pwm_select,
    output logic [7:0] sfr_rdata,
    output logic cycle_overflow_irq,
    output logic cycle_overflow_flag,
    output logic [NUM_MODULES*16-1:0] module_compare_value,
    output logic [NUM_MODULES*5-1:0] module_cycle_bits
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Asserts at once, releases two clocks later
    logic [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    logic reload_bank_select_reg;
    logic cycle_overflow_irq_enable_reg;
    logic cycle_overflow_flag_reg;
    logic [1:0] cycle_length_select_reg;
    logic irq_reg;
    logic [7:0] rdata_reg;

    wire cfg_hit = sfr_addr == pcc_pkg::CONFIG_ADDR;
    wire cfg_wr = sfr_wr & cfg_hit;
    wire ovf_pulse;
    // Hardware set beats a same-cycle software clear
    wire flag_next = ovf_pulse | (cfg_wr ? sfr_wdata[pcc_pkg::FLAG_BIT] : cycle_overflow_flag_reg);
    // Reserved positions are never stored and read as zero
    wire [7:0] config_view = {reload_bank_select_reg, cycle_overflow_irq_enable_reg,
        cycle_overflow_flag_reg, pcc_pkg::RSVD_VALUE, cycle_length_select_reg};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reload_bank_select_reg <= pcc_pkg::CONFIG_RESET[pcc_pkg::BANK_BIT];
            cycle_overflow_irq_enable_reg <= pcc_pkg::CONFIG_RESET[pcc_pkg::IRQ_EN_BIT];
            cycle_overflow_flag_reg <= pcc_pkg::CONFIG_RESET[pcc_pkg::FLAG_BIT];
            cycle_length_select_reg <= pcc_pkg::CONFIG_RESET[pcc_pkg::LEN_LSB +: pcc_pkg::LEN_W];
        end
        else
        begin
            if (cfg_wr)
            begin
                reload_bank_select_reg <= sfr_wdata[pcc_pkg::BANK_BIT];
                cycle_overflow_irq_enable_reg <= sfr_wdata[pcc_pkg::IRQ_EN_BIT];
                cycle_length_select_reg <= sfr_wdata[pcc_pkg::LEN_LSB +: pcc_pkg::LEN_W];
            end
            cycle_overflow_flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------
    // Cycle overflow detection
    // ------------------------------------------------------------
    pcc_ovf_if ovf_bus ();

    assign ovf_bus.count = main_counter;
    // A length change cannot fake an overflow
    assign ovf_bus.length_sel = cycle_length_select_reg;
    assign ovf_pulse = ovf_bus.overflow;

    pcc_overflow_detect u_detect (
        .clk(clk),
        .rst_n(rst_n),
        .ovf(ovf_bus.detect)
    );

    // ------------------------------------------------------------
    // Compare slot decode
    // ------------------------------------------------------------
    function automatic logic slot_hit(input logic [7:0] addr, input logic [7:0] base, input int idx);
        return addr == 8'(base + idx);
    endfunction : slot_hit

    // ------------------------------------------------------------
    // Per-module compare and reload values
    // ------------------------------------------------------------
    wire [7:0] low_view [NUM_MODULES];
    wire [7:0] high_view [NUM_MODULES];
    wire [NUM_MODULES-1:0] low_hit;
    wire [NUM_MODULES-1:0] high_hit;
    wire long_cycle = cycle_length_select_reg != pcc_pkg::LEN_8;
    wire [4:0] shared_bits = pcc_pkg::cycle_bits(cycle_length_select_reg);

    genvar n;
    generate
        for (n = 0; n < NUM_MODULES; n++)
        begin : g_mod
            logic [15:0] cmp_reg;
            logic [15:0] reload_reg;
            logic [4:0] bits_reg;

            assign low_hit[n] = slot_hit(sfr_addr, pcc_pkg::CMP_LOW_BASE, n);
            assign high_hit[n] = slot_hit(sfr_addr, pcc_pkg::CMP_HIGH_BASE, n);
            wire low_wr = sfr_wr & low_hit[n];
            wire high_wr = sfr_wr & high_hit[n];
            // Bank bit steers the shared addresses
            wire cmp_low_wr = low_wr & ~reload_bank_select_reg;
            wire cmp_high_wr = high_wr & ~reload_bank_select_reg;
            wire rl_low_wr = low_wr & reload_bank_select_reg;
            wire rl_high_wr = high_wr & reload_bank_select_reg;
            assign low_view[n] = reload_bank_select_reg ? reload_reg[7:0] : cmp_reg[7:0];
            assign high_view[n] = reload_bank_select_reg ? reload_reg[15:8] : cmp_reg[15:8];

            wire narrow_pwm = pwm_mode_en[n] & ~wide_pwm_select[n];
            // Reload only in 9, 10 and 11-bit PWM
            wire reload_now = ovf_pulse & narrow_pwm & long_cycle;
            wire [15:0] cmp_base = reload_now ? reload_reg : cmp_reg;
            // Software write wins over the reload
            wire [15:0] cmp_next = {cmp_high_wr ? sfr_wdata : cmp_base[15:8],
                cmp_low_wr ? sfr_wdata : cmp_base[7:0]};
            wire [15:0] reload_next = {rl_high_wr ? sfr_wdata : reload_reg[15:8],
                rl_low_wr ? sfr_wdata : reload_reg[7:0]};
            // Zero marks a module with PWM off
            wire [4:0] bits_next = !pwm_mode_en[n] ? pcc_pkg::BITS_NONE :
                wide_pwm_select[n] ? pcc_pkg::BITS_WIDE : shared_bits;

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cmp_reg <= pcc_pkg::VALUE_RESET;
                    reload_reg <= pcc_pkg::VALUE_RESET;
                    bits_reg <= pcc_pkg::BITS_NONE;
                end
                else
                begin
                    cmp_reg <= cmp_next;
                    reload_reg <= reload_next;
                    bits_reg <= bits_next;
                end
            end

            assign module_compare_value[n*16 +: 16] = cmp_reg;
            assign module_cycle_bits[n*5 +: 5] = bits_reg;
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rd_next;

    always_comb
    begin
        rd_next = pcc_pkg::READ_IDLE;
        if (cfg_hit)
            rd_next = config_view;
        // Decoded addresses do not overlap while NUM_MODULES is 8 or less
        for (int i = 0; i < NUM_MODULES; i++)
        begin
            if (low_hit[i])
                rd_next = low_view[i];
            if (high_hit[i])
                rd_next = high_view[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= pcc_pkg::READ_IDLE;
        else if (sfr_rd)
            rdata_reg <= rd_next;
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    // Level request, one clock behind the flag
    wire irq_next = cycle_overflow_flag_reg & cycle_overflow_irq_enable_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_reg <= 1'b0;
        else
            irq_reg <= irq_next;
    end

    assign sfr_rdata = rdata_reg;
    assign cycle_overflow_irq = irq_reg;
    assign cycle_overflow_flag = cycle_overflow_flag_reg;

endmodule : pcc_cycle_config

`default_nettype wire

// file: verilog/pcc_overflow_detect.sv
`default_nettype none

module pcc_overflow_detect (
    input wire logic clk,
    input wire logic rst_n,
    pcc_ovf_if.detect ovf
);

    // ------------------------------------------------------------
    // Carry out of the selected counter bit
    // ------------------------------------------------------------
    logic [pcc_pkg::LONG_BITS-1:0] prev_reg;
    wire [4:0] sel_bits = pcc_pkg::cycle_bits(ovf.length_sel);
    wire [3:0] top_idx = 4'(sel_bits - pcc_pkg::BITS_ONE);
    wire was_high = prev_reg[top_idx];
    wire now_low = ~ovf.count[top_idx];

    // Falling top bit marks the wrap of the low cycle bits
    assign ovf.overflow = was_high & now_low;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_reg <= '0;
        else
            prev_reg <= ovf.count[pcc_pkg::LONG_BITS-1:0];
    end

endmodule : pcc_overflow_detect

`default_nettype wire

// file: verilog/pcc_ovf_if.sv
`default_nettype none

interface pcc_ovf_if;
    logic [pcc_pkg::CNT_W-1:0] count;
    logic [pcc_pkg::LEN_W-1:0] length_sel;
    logic overflow;

    modport detect (input count, input length_sel, output overflow);
    modport ctrl (output count, output length_sel, input overflow);
endinterface : pcc_ovf_if

`default_nettype wire

// file: verilog/pcc_pkg.sv
`default_nettype none

package pcc_pkg;

    // ------------------------------------------------------------
    // Bus and datapath widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int BITS_W = 5;
    localparam int LONG_BITS = 11;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CONFIG_ADDR = 8'hF4;
    localparam logic [7:0] CMP_LOW_BASE = 8'hE0;
    localparam logic [7:0] CMP_HIGH_BASE = 8'hE8;

    // ------------------------------------------------------------
    // Configuration register layout
    // ------------------------------------------------------------
    localparam int BANK_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int FLAG_BIT = 5;
    localparam int LEN_LSB = 0;
    localparam int LEN_W = 2;
    localparam logic [2:0] RSVD_VALUE = 3'h0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Cycle length codes and widths
    // ------------------------------------------------------------
    localparam logic [1:0] LEN_8 = 2'h0;
    localparam logic [1:0] LEN_9 = 2'h1;
    localparam logic [1:0] LEN_10 = 2'h2;
    localparam logic [1:0] LEN_11 = 2'h3;
    localparam logic [4:0] BITS_NONE = 5'h00;
    localparam logic [4:0] BITS_8 = 5'h08;
    localparam logic [4:0] BITS_9 = 5'h09;
    localparam logic [4:0] BITS_10 = 5'h0A;
    localparam logic [4:0] BITS_11 = 5'h0B;
    localparam logic [4:0] BITS_WIDE = 5'h10;
    localparam logic [4:0] BITS_ONE = 5'h01;

    function automatic logic [4:0] cycle_bits(input logic [1:0] sel);
        logic [4:0] bits;
        bits = BITS_8;
        unique case (sel)
            LEN_8: bits = BITS_8;
            LEN_9: bits = BITS_9;
            LEN_10: bits = BITS_10;
            LEN_11: bits = BITS_11;
        endcase
        return bits;
    endfunction : cycle_bits

endpackage : pcc_pkg

`default_nettype wire
